// ===== src/mrb_burst_order.sv
`timescale 1ns/1ps
module mrb_burst_order import mrb_pkg::*; (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       start_in,
    input  mrb_burst_s      req_in,
    output logic            busy_out,
    output logic            beat_valid_out,
    output logic [4:0]      beat_addr_out
);

    logic [4:0] beat_reg;
    mrb_burst_s req_reg;

    // Word address of a beat for the captured request
    function automatic logic [4:0] beat_word(input mrb_burst_s r,
                                             input logic [4:0] b);
        logic [1:0] grp;
        grp = 2'b00;
        if (r.write) begin
            beat_word = r.len32 ? b : {r.col_hi[2], b[3:0]};
        end else begin
            grp = r.col_hi[1:0] + b[3:2];
            beat_word = {r.col_hi[2] ^ b[4], grp, 2'b00};
            beat_word = beat_word | {3'b000, b[1:0]};
        end
    endfunction : beat_word

    // Beat counter and request capture
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            busy_out <= 1'b0;
            beat_reg <= 5'h00;
            req_reg <= '0;
        end else if (start_in && !busy_out) begin
            busy_out <= 1'b1;
            beat_reg <= 5'h00;
            req_reg <= req_in;
        end else if (busy_out) begin
            beat_reg <= beat_reg + 5'h01;
            if (beat_reg == {req_reg.len32, 4'hf}) begin
                busy_out <= 1'b0;
            end
        end
    end

    // Registered beat output
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            beat_valid_out <= 1'b0;
            beat_addr_out <= 5'h00;
        end else begin
            beat_valid_out <= busy_out;
            beat_addr_out <= beat_word(req_reg, beat_reg);
        end
    end

endmodule : mrb_burst_order

// ===== src/mrb_latency_decode.sv
`timescale 1ns/1ps
module mrb_latency_decode import mrb_pkg::*; (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic [2:0] rl_code_in,
    input  wire logic [2:0] wl_code_in,
    input  wire logic       wl_set_b_in,
    input  wire logic       read_inv_in,
    output mrb_lat_t        read_latency_out,
    output mrb_lat_t        read_to_precharge_delay_out,
    output mrb_lat_t        write_latency_out
);

    // Registered table lookup of active latencies
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            read_latency_out <= MRB_RL_TAB[0];
            read_to_precharge_delay_out <= MRB_RTP_TAB[0];
            write_latency_out <= MRB_WL_A_TAB[0];
        end else begin
            read_latency_out <= read_inv_in ? MRB_RL_DBI_TAB[rl_code_in]
                                            : MRB_RL_TAB[rl_code_in];
            read_to_precharge_delay_out <= MRB_RTP_TAB[rl_code_in];
            write_latency_out <= wl_set_b_in ? MRB_WL_B_TAB[wl_code_in]
                                             : MRB_WL_A_TAB[wl_code_in];
        end
    end

endmodule : mrb_latency_decode

// ===== src/mrb_mode_regs.sv
`timescale 1ns/1ps
module mrb_mode_regs import mrb_pkg::*; (
    input  wire logic       clk_in,
    input  wire logic       srst_in,
    input  wire logic       cmd_valid_in,
    input  mrb_cmd_s        cmd_in,
    input  wire logic       burst_start_in,
    input  mrb_burst_s      burst_in,
    input  wire logic       setpoint_write_sel_in,
    input  wire logic       setpoint_operate_sel_in,
    input  wire logic [2:0] rate_code_in,
    output logic            rd_valid_out,
    output logic [7:0]      rd_data_out,
    output logic            cmd_refused_out,
    output logic            burst_busy_out,
    output logic            beat_valid_out,
    output logic [4:0]      beat_addr_out,
    output mrb_lat_t        read_latency_out,
    output mrb_lat_t        read_to_precharge_delay_out,
    output mrb_lat_t        write_latency_out,
    output logic            write_leveling_out,
    output logic [2:0]      pull_down_strength_out,
    output logic            pull_up_cal_point_out,
    output logic            write_postamble_len_out,
    output logic            read_inversion_en_out,
    output logic            write_inversion_en_out,
    output logic            repair_mode_out,
    output logic            self_refresh_abort_out,
    output logic [1:0]      thermal_offset_out,
    output logic            derate_out,
    output logic            rate_invalid_out,
    output logic            impedance_cal_reset_out
);

    // ----------------------------------------------------------------
    // Storage
    // ----------------------------------------------------------------
    logic [7:0] latency_setting_reg [2];
    logic [7:0] io_interface_control_reg [2];
    logic       repair_protect_reg;
    logic       repair_entry_reg;
    logic       self_refresh_abort_reg;
    logic [1:0] thermal_offset_reg;
    logic       temp_update_flag_reg;
    logic [2:0] rate_prev_reg;
    logic       wr_lev_reg;
    logic [7:0] lat_op;
    logic [7:0] ioc_op;
    logic       mode_wr;
    logic       mode_rd;
    logic       rate_changed;
    logic       burst_go;

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    // Leveling blocks every command but a mode write
    assign mode_wr = cmd_valid_in && cmd_in.write;
    assign mode_rd = cmd_valid_in && !cmd_in.write && !wr_lev_reg;
    assign burst_go = burst_start_in && !wr_lev_reg && !burst_busy_out;
    assign rate_changed = rate_code_in != rate_prev_reg;
    assign lat_op = latency_setting_reg[setpoint_operate_sel_in];
    assign ioc_op = io_interface_control_reg[setpoint_operate_sel_in];

    // Per set-point copies, written through write select
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            latency_setting_reg[0] <= MRB_LATENCY_RST;
            latency_setting_reg[1] <= MRB_LATENCY_RST;
            io_interface_control_reg[0] <= MRB_IOCTL_RST;
            io_interface_control_reg[1] <= MRB_IOCTL_RST;
        end else if (mode_wr) begin
            if (cmd_in.addr == MRB_ADDR_LATENCY) begin
                latency_setting_reg[setpoint_write_sel_in] <= cmd_in.data;
            end
            if (cmd_in.addr == MRB_ADDR_IOCTL) begin
                io_interface_control_reg[setpoint_write_sel_in] <=
                    cmd_in.data;
            end
        end
    end

    // Write leveling state follows bit 7 of each mode write to the latency register
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            wr_lev_reg <= 1'b0;
        end else if (mode_wr && cmd_in.addr == MRB_ADDR_LATENCY) begin
            wr_lev_reg <= cmd_in.data[MRB_LAT_LEV_BIT];
        end
    end

    // Sticky repair protection, cleared only by reset
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            repair_protect_reg <= 1'b0;
        end else if (mode_wr && cmd_in.addr == MRB_ADDR_IOCTL &&
                     cmd_in.data[MRB_IO_PROT_BIT]) begin
            repair_protect_reg <= 1'b1;
        end
    end

    // Thermal register writable bits 6..3
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            {thermal_offset_reg, repair_entry_reg, self_refresh_abort_reg}
                <= MRB_THERMAL_WR_RST;
        end else if (mode_wr && cmd_in.addr == MRB_ADDR_THERMAL) begin
            self_refresh_abort_reg <= cmd_in.data[MRB_TH_SRA_BIT];
            thermal_offset_reg <= cmd_in.data[MRB_TH_OFS_LSB +: 2];
            if (!(repair_protect_reg && cmd_in.data[MRB_TH_REPAIR_ENTRY_BIT])) begin
                repair_entry_reg <= cmd_in.data[MRB_TH_REPAIR_ENTRY_BIT];
            end
        end
    end

    // Update flag; a change in the clearing cycle wins
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            temp_update_flag_reg <= 1'b0;
            rate_prev_reg <= rate_code_in;
        end else begin
            rate_prev_reg <= rate_code_in;
            if (rate_changed) begin
                temp_update_flag_reg <= 1'b1;
            end else if (mode_rd && cmd_in.addr == MRB_ADDR_THERMAL) begin
                temp_update_flag_reg <= 1'b0;
            end
        end
    end

    // ----------------------------------------------------------------
    // Mode read path
    // ----------------------------------------------------------------
    // One-cycle read answer, unmapped addresses read zero
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            rd_valid_out <= 1'b0;
            rd_data_out <= 8'h00;
        end else begin
            rd_valid_out <= mode_rd;
            rd_data_out <= 8'h00;
            if (mode_rd) begin
                unique case (cmd_in.addr)
                    MRB_ADDR_LATENCY: begin
                        rd_data_out <=
                            latency_setting_reg[setpoint_write_sel_in];
                    end
                    MRB_ADDR_IOCTL: begin
                        rd_data_out <=
                            io_interface_control_reg[setpoint_write_sel_in]
                            | {5'h00, repair_protect_reg, 2'b00};
                    end
                    MRB_ADDR_THERMAL: begin
                        rd_data_out <= {temp_update_flag_reg,
                            thermal_offset_reg, repair_entry_reg,
                            self_refresh_abort_reg, rate_code_in};
                    end
                    MRB_ADDR_PARTCFG: begin
                        rd_data_out <= MRB_PARTCFG_VAL;
                    end
                    default: begin
                        rd_data_out <= 8'h00;
                    end
                endcase
            end
        end
    end

    // Refusal pulse for commands blocked during leveling
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            cmd_refused_out <= 1'b0;
        end else begin
            cmd_refused_out <= wr_lev_reg &&
                ((cmd_valid_in && !cmd_in.write) || burst_start_in);
        end
    end

    // ----------------------------------------------------------------
    // Operating outputs; I/O control fields from the active copy
    // ----------------------------------------------------------------
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            write_leveling_out <= 1'b0;
            pull_down_strength_out <= MRB_IOCTL_RST[MRB_IO_PULL_DOWN_STRENGTH_LSB +: 3];
            pull_up_cal_point_out <= MRB_IOCTL_RST[MRB_IO_PUCAL_BIT];
            write_postamble_len_out <= MRB_IOCTL_RST[MRB_IO_PST_BIT];
            read_inversion_en_out <= MRB_IOCTL_RST[MRB_IO_DBIRD_BIT];
            write_inversion_en_out <= MRB_IOCTL_RST[MRB_IO_DBIWR_BIT];
            repair_mode_out <= 1'b0;
            self_refresh_abort_out <= 1'b0;
            thermal_offset_out <= 2'b00;
            derate_out <= 1'b0;
            rate_invalid_out <= 1'b0;
        end else begin
            write_leveling_out <= wr_lev_reg;
            pull_down_strength_out <= ioc_op[MRB_IO_PULL_DOWN_STRENGTH_LSB +: 3];
            pull_up_cal_point_out <= ioc_op[MRB_IO_PUCAL_BIT];
            write_postamble_len_out <= ioc_op[MRB_IO_PST_BIT];
            read_inversion_en_out <= ioc_op[MRB_IO_DBIRD_BIT];
            write_inversion_en_out <= ioc_op[MRB_IO_DBIWR_BIT];
            repair_mode_out <= repair_entry_reg;
            self_refresh_abort_out <= self_refresh_abort_reg;
            thermal_offset_out <= thermal_offset_reg;
            derate_out <= rate_code_in == MRB_RATE_DERATE;
            rate_invalid_out <= rate_code_in == MRB_RATE_BAD_LO ||
                                rate_code_in == MRB_RATE_BAD_HI;
        end
    end

    // Calibration reset pulse, register is write-only
    always_ff @(posedge clk_in) begin
        if (srst_in) begin
            impedance_cal_reset_out <= 1'b0;
        end else begin
            impedance_cal_reset_out <= mode_wr &&
                cmd_in.addr == MRB_ADDR_CALRST &&
                cmd_in.data[MRB_CAL_RST_BIT];
        end
    end

    // ----------------------------------------------------------------
    // Submodules
    // ----------------------------------------------------------------
    mrb_latency_decode u_lat (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .rl_code_in(lat_op[MRB_LAT_RL_LSB +: 3]),
        .wl_code_in(lat_op[MRB_LAT_WL_LSB +: 3]),
        .wl_set_b_in(lat_op[MRB_LAT_WLS_BIT]),
        .read_inv_in(ioc_op[MRB_IO_DBIRD_BIT]),
        .read_latency_out(read_latency_out),
        .read_to_precharge_delay_out(read_to_precharge_delay_out),
        .write_latency_out(write_latency_out)
    );

    mrb_burst_order u_burst (
        .clk_in(clk_in),
        .srst_in(srst_in),
        .start_in(burst_go),
        .req_in(burst_in),
        .busy_out(burst_busy_out),
        .beat_valid_out(beat_valid_out),
        .beat_addr_out(beat_addr_out)
    );

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    sequence s_thermal_read;
        mode_rd && cmd_in.addr == MRB_ADDR_THERMAL && !rate_changed;
    endsequence

    property p_tuf_clear;
        @(posedge clk_in) disable iff (srst_in)
        s_thermal_read |=> !temp_update_flag_reg;
    endproperty
    a_tuf_clear: assert property (p_tuf_clear)
        else $error("update flag not cleared by thermal read");

    property p_tuf_set;
        @(posedge clk_in) disable iff (srst_in)
        rate_changed |=> temp_update_flag_reg;
    endproperty
    a_tuf_set: assert property (p_tuf_set)
        else $error("update flag not set on rate change");

    property p_protect_sticky;
        @(posedge clk_in) disable iff (srst_in)
        repair_protect_reg |=> repair_protect_reg;
    endproperty
    a_protect_sticky: assert property (p_protect_sticky)
        else $error("repair protect cleared without reset");

    property p_protect_blocks;
        @(posedge clk_in) disable iff (srst_in)
        repair_protect_reg && !repair_entry_reg |=> !repair_entry_reg;
    endproperty
    a_protect_blocks: assert property (p_protect_blocks)
        else $error("repair entry set while protected");

    property p_lev_refuse;
        @(posedge clk_in) disable iff (srst_in)
        wr_lev_reg && cmd_valid_in && !cmd_in.write |=> !rd_valid_out;
    endproperty
    a_lev_refuse: assert property (p_lev_refuse)
        else $error("mode read answered during leveling");

    property p_calrst_pulse;
        @(posedge clk_in) disable iff (srst_in)
        impedance_cal_reset_out |=> !impedance_cal_reset_out ||
            $past(mode_wr);
    endproperty
    a_calrst_pulse: assert property (p_calrst_pulse)
        else $error("calibration reset held without write");

    property p_partcfg_zero;
        @(posedge clk_in) disable iff (srst_in)
        mode_rd && cmd_in.addr == MRB_ADDR_PARTCFG |=>
            rd_valid_out && rd_data_out == 8'h00;
    endproperty
    a_partcfg_zero: assert property (p_partcfg_zero)
        else $error("configuration register not zero");

    property p_rl_min;
        @(posedge clk_in) disable iff (srst_in)
        $stable(lat_op) && $stable(ioc_op) && lat_op[2:0] == 3'h0 |=>
            read_latency_out == 6'd6 && read_to_precharge_delay_out == 6'd8;
    endproperty
    a_rl_min: assert property (p_rl_min)
        else $error("read latency code 0 mis-decoded");

    property p_burst16_len;
        @(posedge clk_in) disable iff (srst_in)
        burst_go && !burst_in.len32 |=> burst_busy_out [*8] ##9
            !burst_busy_out;
    endproperty
    a_burst16_len: assert property (p_burst16_len)
        else $error("16-beat burst length wrong");

endmodule : mrb_mode_regs

// ===== src/mrb_pkg.sv
package mrb_pkg;

    // ----------------------------------------------------------------
    // Register addresses
    // ----------------------------------------------------------------
    localparam logic [5:0] MRB_ADDR_LATENCY = 6'h02;
    localparam logic [5:0] MRB_ADDR_IOCTL = 6'h03;
    localparam logic [5:0] MRB_ADDR_THERMAL = 6'h04;
    localparam logic [5:0] MRB_ADDR_PARTCFG = 6'h08;
    localparam logic [5:0] MRB_ADDR_RSVD9 = 6'h09;
    localparam logic [5:0] MRB_ADDR_CALRST = 6'h0a;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int MRB_LAT_RL_LSB = 0;
    localparam int MRB_LAT_WL_LSB = 3;
    localparam int MRB_LAT_WLS_BIT = 6;
    localparam int MRB_LAT_LEV_BIT = 7;
    localparam int MRB_IO_PUCAL_BIT = 0;
    localparam int MRB_IO_PST_BIT = 1;
    localparam int MRB_IO_PROT_BIT = 2;
    localparam int MRB_IO_PULL_DOWN_STRENGTH_LSB = 3;
    localparam int MRB_IO_DBIRD_BIT = 6;
    localparam int MRB_IO_DBIWR_BIT = 7;
    localparam int MRB_TH_SRA_BIT = 3;
    localparam int MRB_TH_REPAIR_ENTRY_BIT = 4;
    localparam int MRB_TH_OFS_LSB = 5;
    localparam int MRB_TH_TUF_BIT = 7;
    localparam int MRB_CAL_RST_BIT = 0;

    // ----------------------------------------------------------------
    // Reset values, fixed read value and rate codes
    // ----------------------------------------------------------------
    localparam logic [7:0] MRB_LATENCY_RST = 8'h00;
    localparam logic [7:0] MRB_IOCTL_RST = 8'h31;
    localparam logic [3:0] MRB_THERMAL_WR_RST = 4'h0;
    localparam logic [7:0] MRB_PARTCFG_VAL = 8'h00;
    localparam logic [2:0] MRB_RATE_DERATE = 3'h6;
    localparam logic [2:0] MRB_RATE_BAD_LO = 3'h0;
    localparam logic [2:0] MRB_RATE_BAD_HI = 3'h7;

    // ----------------------------------------------------------------
    // Latency tables, indexed by code
    // ----------------------------------------------------------------
    typedef logic [5:0] mrb_lat_t;
    localparam mrb_lat_t MRB_RL_TAB [8] = '{
        6'd6, 6'd10, 6'd14, 6'd20, 6'd24, 6'd28, 6'd32, 6'd36};
    localparam mrb_lat_t MRB_RL_DBI_TAB [8] = '{
        6'd6, 6'd12, 6'd16, 6'd22, 6'd28, 6'd32, 6'd36, 6'd40};
    localparam mrb_lat_t MRB_RTP_TAB [8] = '{
        6'd8, 6'd8, 6'd8, 6'd8, 6'd10, 6'd12, 6'd14, 6'd16};
    localparam mrb_lat_t MRB_WL_A_TAB [8] = '{
        6'd4, 6'd6, 6'd8, 6'd10, 6'd12, 6'd14, 6'd16, 6'd18};
    localparam mrb_lat_t MRB_WL_B_TAB [8] = '{
        6'd4, 6'd8, 6'd12, 6'd18, 6'd22, 6'd26, 6'd30, 6'd34};

    // ----------------------------------------------------------------
    // Carriers
    // ----------------------------------------------------------------
    typedef struct packed {
        logic       write;
        logic [5:0] addr;
        logic [7:0] data;
    } mrb_cmd_s;

    typedef struct packed {
        logic       write;
        logic       len32;
        logic [2:0] col_hi;
    } mrb_burst_s;

endpackage : mrb_pkg

// ===== tb/mrb_host.sv
`timescale 1ns/1ps
module mrb_host import mrb_pkg::*; (
    input wire logic clk_in,
    input wire logic rd_valid_in,
    input wire logic [7:0] rd_data_in,
    output logic cmd_valid_out,
    output mrb_cmd_s cmd_out,
    output logic burst_start_out,
    output mrb_burst_s burst_out
);
    // Idle bus at time zero
    initial begin
        cmd_valid_out = 1'b0;
        cmd_out = '0;
        burst_start_out = 1'b0;
        burst_out = '0;
    end
    // Mode command over one taking edge; answer sampled while it stands
    task automatic cmd(input logic w, input logic [5:0] a,
        input logic [7:0] d, output logic v, output logic [7:0] q);
        @(negedge clk_in);
        cmd_valid_out = 1'b1;
        cmd_out = '{w, a, d};
        @(negedge clk_in);
        v = rd_valid_in;
        q = rd_data_in;
        cmd_valid_out = 1'b0;
        cmd_out = ~cmd_out;
    endtask : cmd
    // Burst start; column bits 3:2 forced low on writes
    task automatic burst(input logic w, input logic l, input logic [2:0] c);
        @(negedge clk_in);
        burst_start_out = 1'b1;
        burst_out = '{w, l, w ? {c[2], 2'b00} : c};
        @(negedge clk_in);
        burst_start_out = 1'b0;
        burst_out = ~burst_out;
    endtask : burst
endmodule : mrb_host

// ===== tb/tb_top.sv
`timescale 1ns/1ps
module tb_top import mrb_pkg::*;;
    logic clk_in = 0, srst_in = 1, wsel = 0, osel = 0;
    logic [2:0] rate = 3'h3, pd;
    logic cv, bs, rv, rf, busy, bv, lev, pu, rinv, rep, der, calr, v;
    logic pst, winv, sra, rbad;
    logic [1:0] tof;
    logic [7:0] rd, q;
    logic [4:0] ba;
    logic [4:0] seen [$];
    mrb_cmd_s c;
    mrb_burst_s b;
    mrb_lat_t rl, rtp, wl;
    int err_total = 0, cmp_count = 0, ncal = 0, nref = 0;
    logic [5:0] ra [7] = '{6'h04, 6'h02, 6'h03, 6'h08, 6'h09, 6'h0a, 6'h3f};
    logic [7:0] rw [7] = '{8'hff, 8'h45, 8'ha9, 8'hff, 8'hff, 8'h00, 8'hff};
    logic [7:0] rx [7] = '{8'h7b, 8'h45, 8'ha9, 8'h00, 8'h00, 8'h00, 8'h00};

    always #20 clk_in = ~clk_in;
    // Beat capture and pulse counting
    always @(posedge clk_in) begin
        if (bv) seen.push_back(ba);
        if (calr) ncal++;
        if (rf) nref++;
    end

    mrb_host i_mrb_host (.clk_in(clk_in), .rd_valid_in(rv), .rd_data_in(rd),
        .cmd_valid_out(cv), .cmd_out(c), .burst_start_out(bs), .burst_out(b));
    mrb_mode_regs i_mrb_mode_regs (.clk_in(clk_in), .srst_in(srst_in),
        .cmd_valid_in(cv), .cmd_in(c), .burst_start_in(bs), .burst_in(b),
        .setpoint_write_sel_in(wsel), .setpoint_operate_sel_in(osel),
        .rate_code_in(rate), .rd_valid_out(rv), .rd_data_out(rd),
        .cmd_refused_out(rf), .burst_busy_out(busy), .beat_valid_out(bv),
        .beat_addr_out(ba), .read_latency_out(rl),
        .read_to_precharge_delay_out(rtp), .write_latency_out(wl),
        .write_leveling_out(lev), .pull_down_strength_out(pd),
        .pull_up_cal_point_out(pu), .write_postamble_len_out(pst),
        .read_inversion_en_out(rinv), .write_inversion_en_out(winv),
        .repair_mode_out(rep), .self_refresh_abort_out(sra),
        .thermal_offset_out(tof), .derate_out(der), .rate_invalid_out(rbad),
        .impedance_cal_reset_out(calr));

    task automatic conclude();
        if (err_total == 0 && cmp_count > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : conclude
    task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
        cmp_count++;
        if (g !== e) begin
            err_total++;
            $display("MISMATCH %s exp %h got %h", n, e, g);
        end
    endtask : chk
    task automatic wr(input logic [5:0] a, input logic [7:0] d);
        i_mrb_host.cmd(1'b1, a, d, v, q);
        @(negedge clk_in);
    endtask : wr
    task automatic rdc(input logic [5:0] a, input logic [7:0] e);
        i_mrb_host.cmd(1'b0, a, 8'h00, v, q);
        chk("rd_valid", 8'h01, {7'h00, v});
        chk("rd_data", e, q);
    endtask : rdc
    // Burst run against the expected word order
    task automatic bchk(input logic w, input logic l, input logic [2:0] cc);
        logic [4:0] k, e;
        seen.delete();
        i_mrb_host.burst(w, l, cc);
        chk("busy", 8'h01, {7'h00, busy});
        repeat (36) @(negedge clk_in);
        chk("beats", l ? 8'h20 : 8'h10, 8'(seen.size()));
        for (int i = 0; i < seen.size(); i++) begin
            k = 5'(i);
            e = w ? (l ? k : {cc[2], k[3:0]})
                : {cc[2] ^ k[4], cc[1:0] + k[3:2], k[1:0]};
            chk("beat_addr", {3'h0, e}, {3'h0, seen[i]});
        end
    endtask : bchk

    // Watchdog
    initial begin
        #200000;
        err_total++;
        conclude();
    end
    // Main sequence
    initial begin
        repeat (10) @(negedge clk_in);
        srst_in = 1'b0;
        @(negedge clk_in);
        chk("rl", 8'h06, {2'b00, rl});
        chk("rtp", 8'h08, {2'b00, rtp});
        chk("wl", 8'h04, {2'b00, wl});
        chk("pd", 8'h06, {5'h00, pd});
        chk("pu", 8'h01, {7'h00, pu});
        for (int i = 0; i < 7; i++) begin
            wr(ra[i], rw[i]);
            rdc(ra[i], rx[i]);
        end
        chk("sra", 8'h01, {7'h00, sra});
        chk("tof", 8'h03, {6'h00, tof});
        chk("winv", 8'h01, {7'h00, winv});
        chk("pst", 8'h00, {7'h00, pst});
        chk("pd", 8'h05, {5'h00, pd});
        wr(6'h02, 8'h6f);
        chk("rl", 8'h24, {2'b00, rl});
        chk("rtp", 8'h10, {2'b00, rtp});
        chk("wl", 8'h1a, {2'b00, wl});
        wr(6'h03, 8'h71);
        chk("rl", 8'h28, {2'b00, rl});
        chk("rinv", 8'h01, {7'h00, rinv});
        wsel = 1'b1;
        wr(6'h02, 8'h00);
        chk("rl", 8'h28, {2'b00, rl});
        rdc(6'h02, 8'h00);
        osel = 1'b1;
        repeat (3) @(negedge clk_in);
        chk("rl", 8'h06, {2'b00, rl});
        wsel = 1'b0;
        osel = 1'b0;
        wr(6'h03, 8'h35);
        wr(6'h04, 8'h00);
        wr(6'h04, 8'h10);
        chk("rep", 8'h00, {7'h00, rep});
        rate = 3'h6;
        repeat (2) @(negedge clk_in);
        chk("der", 8'h01, {7'h00, der});
        rdc(6'h04, 8'h86);
        rdc(6'h04, 8'h06);
        wr(6'h0a, 8'h01);
        chk("ncal", 8'h01, 8'(ncal));
        wr(6'h02, 8'h80);
        chk("lev", 8'h01, {7'h00, lev});
        i_mrb_host.cmd(1'b0, 6'h04, 8'h00, v, q);
        chk("rd_valid", 8'h00, {7'h00, v});
        @(negedge clk_in);
        chk("refused", 8'h01, 8'(nref));
        wr(6'h02, 8'h00);
        chk("lev", 8'h00, {7'h00, lev});
        bchk(1'b0, 1'b1, 3'h5);
        bchk(1'b0, 1'b0, 3'h6);
        bchk(1'b1, 1'b0, 3'h4);
        bchk(1'b1, 1'b1, 3'h7);
        rate = 3'h7;
        repeat (2) @(negedge clk_in);
        chk("rbad", 8'h01, {7'h00, rbad});
        chk("der", 8'h00, {7'h00, der});
        // Mid-run reset clears sticky protect and update flag
        srst_in = 1'b1;
        repeat (2) @(negedge clk_in);
        srst_in = 1'b0;
        rdc(6'h03, 8'h31);
        rdc(6'h04, 8'h07);
        conclude();
    end
endmodule : tb_top
